// ==== core/aclc_top.sv ====
// Armature current loop supervision and firing control
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module aclc_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive signals
  input wire logic [9:0] current_feedback,
  input wire logic [9:0] speed_feedback,
  input wire logic [9:0] post_ramp_reference,
  input wire logic [9:0] current_demand,
  input wire logic [9:0] loop_error,
  input wire logic start_command,
  input wire logic stop_command,
  input wire logic zero_reference,
  input wire logic tune_done,
  input wire logic cyclic_reset,
  input wire logic bridge2_quadrant_enabled,
  input wire logic bridge_change_request,
  input wire logic partner_lockout_input,
  // Outputs
  output logic [9:0] firing_angle,
  output logic fire_enable,
  output logic ramp_reset,
  output logic overload_trip,
  output logic drive_ready,
  output logic tune_active,
  output logic [10:0] endstop_limit,
  output logic [17:0] di_gain_term,
  output logic [17:0] cp_gain_term,
  output logic [17:0] ci_gain_term,
  output logic [17:0] scaled_demand,
  output logic high_gain_discontinuous,
  output logic divert_series_twelve,
  output logic bridge_change_grant,
  output logic lockout_status_output
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] heat_q, cool_q, digain_q, cpgain_q, cigain_q, mconst_q;
  logic tune_en_q, endstop_q, inhibit_q, ssen_q, ssmode_q, direct_q;
  logic lockout_q, adapt_dis_q, sq12_q, ser12_q, par12_q;
  logic [9:0] olthr_q;
  logic [10:0] acc_q, acc_d;
  logic [7:0] olcnt_q;
  logic trip_q;
  logic [22:0] tune_cnt_q;
  logic [14:0] tick_cnt_q;
  logic [7:0] ss_cnt_q;
  logic sample_q;
  aclc_pkg::tune_state_type tune_q;
  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire wr = psel && penable && pwrite;
  wire hit_known = (paddr <= aclc_pkg::OFS_STATUS) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_known;
  wire tune_clear = (tune_q == aclc_pkg::TUNE_OPEN) &&
    (tune_cnt_q == 23'(aclc_pkg::READY_OPEN_CYC - 1));
  // Product needs 14 bits, held in 15, before the divide by 16; threshold is clamped so no underflow
  wire [14:0] trip_prod = (15'(aclc_pkg::FULL_SCALE) - 15'(olthr_q)) * 15'd10;
  wire [10:0] trip_level = trip_prod[14:4];
  always_comb begin
    unique case (paddr)
      aclc_pkg::OFS_HEAT: prdata = {24'h0, heat_q};
      aclc_pkg::OFS_COOL: prdata = {24'h0, cool_q};
      aclc_pkg::OFS_TUNE: prdata = {31'h0, tune_en_q};
      aclc_pkg::OFS_ENDSTOP: prdata = {31'h0, endstop_q};
      aclc_pkg::OFS_ACCUM: prdata = {21'h0, acc_q};
      aclc_pkg::OFS_DIGAIN: prdata = {24'h0, digain_q};
      aclc_pkg::OFS_CPGAIN: prdata = {24'h0, cpgain_q};
      aclc_pkg::OFS_CIGAIN: prdata = {24'h0, cigain_q};
      aclc_pkg::OFS_MCONST: prdata = {24'h0, mconst_q};
      aclc_pkg::OFS_INHIBIT: prdata = {31'h0, inhibit_q};
      aclc_pkg::OFS_SSEN: prdata = {31'h0, ssen_q};
      aclc_pkg::OFS_SSMODE: prdata = {31'h0, ssmode_q};
      aclc_pkg::OFS_DIRECT: prdata = {31'h0, direct_q};
      aclc_pkg::OFS_LOCKOUT: prdata = {31'h0, lockout_q};
      aclc_pkg::OFS_ADAPT: prdata = {31'h0, adapt_dis_q};
      aclc_pkg::OFS_SQ12: prdata = {31'h0, sq12_q};
      aclc_pkg::OFS_SER12: prdata = {31'h0, ser12_q};
      aclc_pkg::OFS_PAR12: prdata = {31'h0, par12_q};
      aclc_pkg::OFS_OLTHR: prdata = {22'h0, olthr_q};
      aclc_pkg::OFS_STATUS: prdata = {29'h0, tune_active, divert_series_twelve, trip_q};
      default: prdata = 32'h0;
    endcase
  end
  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_q <= aclc_pkg::RST_HEAT;
      cool_q <= aclc_pkg::RST_COOL;
      digain_q <= aclc_pkg::RST_GAIN;
      cpgain_q <= aclc_pkg::RST_GAIN;
      cigain_q <= aclc_pkg::RST_GAIN;
      mconst_q <= aclc_pkg::RST_MCONST;
      tune_en_q <= 1'b0;
      endstop_q <= 1'b0;
      inhibit_q <= 1'b0;
      ssen_q <= aclc_pkg::RST_SSEN;
      ssmode_q <= 1'b0;
      direct_q <= 1'b0;
      lockout_q <= 1'b0;
      adapt_dis_q <= 1'b0;
      ser12_q <= 1'b0;
      par12_q <= 1'b0;
      olthr_q <= aclc_pkg::RST_OLTHR;
    end else begin
      if (tune_clear) begin
        tune_en_q <= 1'b0;
      end else if (wr && paddr == aclc_pkg::OFS_TUNE) begin
        tune_en_q <= pwdata[0];
      end
      if (wr) begin
        unique case (paddr)
          aclc_pkg::OFS_HEAT: heat_q <= pwdata[7:0];
          aclc_pkg::OFS_COOL: cool_q <= pwdata[7:0];
          aclc_pkg::OFS_ENDSTOP: endstop_q <= pwdata[0];
          aclc_pkg::OFS_DIGAIN: digain_q <= pwdata[7:0];
          aclc_pkg::OFS_CPGAIN: cpgain_q <= pwdata[7:0];
          aclc_pkg::OFS_CIGAIN: cigain_q <= pwdata[7:0];
          aclc_pkg::OFS_MCONST: mconst_q <= pwdata[7:0];
          aclc_pkg::OFS_INHIBIT: inhibit_q <= pwdata[0];
          aclc_pkg::OFS_SSEN: ssen_q <= pwdata[0];
          aclc_pkg::OFS_SSMODE: ssmode_q <= pwdata[0];
          aclc_pkg::OFS_DIRECT: direct_q <= pwdata[0];
          aclc_pkg::OFS_LOCKOUT: lockout_q <= pwdata[0];
          aclc_pkg::OFS_ADAPT: adapt_dis_q <= pwdata[0];
          aclc_pkg::OFS_SER12: ser12_q <= pwdata[0];
          aclc_pkg::OFS_PAR12: par12_q <= pwdata[0];
          aclc_pkg::OFS_OLTHR: olthr_q <= (pwdata[9:0] > aclc_pkg::FULL_SCALE) ? aclc_pkg::FULL_SCALE : pwdata[9:0];
          default: ;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Series 12-pulse request, sampled at reset
  // ----------------------------------------
  // Request is taken once after power-on or a cyclic reset; writes between are latched but unused
  logic sq12_req_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq12_req_q <= 1'b0;
      sq12_q <= 1'b0;
      sample_q <= 1'b1;
      divert_series_twelve <= 1'b0;
    end else begin
      if (wr && paddr == aclc_pkg::OFS_SQ12) begin
        sq12_req_q <= pwdata[0];
        sq12_q <= pwdata[0];
      end
      sample_q <= cyclic_reset;
      if (sample_q) begin
        divert_series_twelve <= sq12_req_q && !bridge2_quadrant_enabled;
        if (bridge2_quadrant_enabled) begin
          sq12_q <= 1'b0;
          sq12_req_q <= 1'b0;
        end
      end
    end
  end
  property p_divert_sampled;
    @(posedge pclk) disable iff (!presetn)
    !sample_q |=> $stable(divert_series_twelve);
  endproperty
  a_divert_sampled: assert property (p_divert_sampled) else $error("Divert moved outside a sample");
  property p_divert_blocked;
    @(posedge pclk) disable iff (!presetn)
    sample_q && bridge2_quadrant_enabled |=> !divert_series_twelve && !sq12_q;
  endproperty
  a_divert_blocked: assert property (p_divert_blocked) else $error("Series request not cleared");
  // ----------------------------------------
  // Overload integrator
  // ----------------------------------------
  // Heat and cool times both zero disable the trip, so the accumulator clears to zero at the next tick and holds there
  wire ol_off = (heat_q == 8'h00) && (cool_q == 8'h00);
  wire above = current_feedback > olthr_q;
  wire [7:0] ol_period = above ? heat_q : cool_q;
  wire ol_step = (olcnt_q >= ol_period - 8'd1) && (ol_period != 8'h00);
  always_comb begin
    acc_d = acc_q;
    if (ol_off) begin
      acc_d = 11'h0;
    end else if (ol_step && above && acc_q < aclc_pkg::ACC_MAX) begin
      acc_d = acc_q + 11'd1;
    end else if (ol_step && !above && acc_q != 11'h0) begin
      acc_d = acc_q - 11'd1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 11'h0;
      olcnt_q <= 8'h0;
      tick_cnt_q <= 15'h0;
      trip_q <= 1'b0;
    end else begin
      if (tick_cnt_q == 15'(aclc_pkg::TICK_CYC - 1)) begin
        tick_cnt_q <= 15'h0;
        olcnt_q <= ol_step ? 8'h0 : olcnt_q + 8'd1;
        acc_q <= acc_d;
      end else begin
        tick_cnt_q <= tick_cnt_q + 15'd1;
      end
      if (!ol_off && acc_q >= trip_level) begin
        trip_q <= 1'b1;
      end else if (cyclic_reset) begin
        trip_q <= 1'b0;
      end
    end
  end
  assign overload_trip = trip_q;
  property p_acc_no_rise;
    @(posedge pclk) disable iff (!presetn)
    !above |=> acc_q <= $past(acc_q);
  endproperty
  a_acc_no_rise: assert property (p_acc_no_rise) else $error("Accumulator rose below threshold");
  property p_acc_tick;
    @(posedge pclk) disable iff (!presetn)
    tick_cnt_q != 15'(aclc_pkg::TICK_CYC - 1) |=> $stable(acc_q);
  endproperty
  a_acc_tick: assert property (p_acc_tick) else $error("Accumulator moved between ticks");
  property p_trip_sets;
    @(posedge pclk) disable iff (!presetn)
    !ol_off && acc_q >= trip_level |=> trip_q;
  endproperty
  a_trip_sets: assert property (p_trip_sets) else $error("Overload trip missed");
  property p_trip_hold;
    @(posedge pclk) disable iff (!presetn)
    trip_q && !cyclic_reset |=> trip_q;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("Overload trip dropped");
  // ----------------------------------------
  // Autotune handshake
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_q <= aclc_pkg::TUNE_IDLE;
      tune_cnt_q <= 23'h0;
    end else begin
      unique case (tune_q)
        aclc_pkg::TUNE_IDLE: begin
          if (tune_en_q && start_command) begin
            tune_q <= aclc_pkg::TUNE_RUN;
          end
        end
        aclc_pkg::TUNE_RUN: begin
          if (tune_done) begin
            tune_q <= aclc_pkg::TUNE_OPEN;
            tune_cnt_q <= 23'h0;
          end
        end
        aclc_pkg::TUNE_OPEN: begin
          tune_cnt_q <= tune_cnt_q + 23'd1;
          if (tune_clear) begin
            tune_q <= aclc_pkg::TUNE_IDLE;
          end
        end
        default: tune_q <= aclc_pkg::TUNE_IDLE;
      endcase
    end
  end
  assign tune_active = (tune_q == aclc_pkg::TUNE_RUN);
  assign drive_ready = (tune_q != aclc_pkg::TUNE_OPEN) && !trip_q;
  property p_tune_start;
    @(posedge pclk) disable iff (!presetn)
    tune_q == aclc_pkg::TUNE_IDLE && tune_en_q && start_command |=> tune_q == aclc_pkg::TUNE_RUN;
  endproperty
  a_tune_start: assert property (p_tune_start) else $error("Autotune did not start");
  property p_tune_done;
    @(posedge pclk) disable iff (!presetn)
    tune_active && tune_done |=> !drive_ready;
  endproperty
  a_tune_done: assert property (p_tune_done) else $error("Ready did not open after tuning");
  property p_tune_clear;
    @(posedge pclk) disable iff (!presetn)
    tune_clear |=> !tune_en_q && tune_q == aclc_pkg::TUNE_IDLE;
  endproperty
  a_tune_clear: assert property (p_tune_clear) else $error("Autotune enable not cleared");
  // ----------------------------------------
  // Endstop and gain scaling
  // ----------------------------------------
  assign endstop_limit = endstop_q ? aclc_pkg::ENDSTOP_REDUCED : aclc_pkg::ENDSTOP_NORMAL;
  // Terms drop the low 9 and 10 product bits, so the /512 and /1024 scaling truncates
  wire [17:0] err_times_di = 18'(loop_error) * 18'(digain_q);
  wire [17:0] err_times_cp = 18'(loop_error) * 18'(cpgain_q);
  wire [17:0] err_times_ci = 18'(loop_error) * 18'(cigain_q);
  assign di_gain_term = {9'h0, err_times_di[17:9]};
  assign cp_gain_term = {9'h0, err_times_cp[17:9]};
  assign ci_gain_term = {10'h0, err_times_ci[17:10]};
  assign scaled_demand = 18'(current_demand) * 18'(mconst_q);
  assign high_gain_discontinuous = !adapt_dis_q;
  // ----------------------------------------
  // Standstill and firing
  // ----------------------------------------
  wire ss_cause = stop_command || (!ssmode_q && zero_reference);
  wire ss_engage = ssen_q && ss_cause && (speed_feedback < aclc_pkg::STANDSTILL_SPEED);
  wire ss_inhibit = ss_cnt_q == 8'(aclc_pkg::SS_DELAY_TICKS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_cnt_q <= 8'h0;
    end else if (!ss_engage) begin
      ss_cnt_q <= 8'h0;
    end else if (!ss_inhibit && tick_cnt_q == 15'h0) begin
      ss_cnt_q <= ss_cnt_q + 8'd1;
    end
  end
  wire [9:0] loop_angle = (current_demand > aclc_pkg::FIRE_MIN) ? current_demand : aclc_pkg::FIRE_MIN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      firing_angle <= aclc_pkg::FIRE_MIN;
    end else if (ss_engage) begin
      firing_angle <= aclc_pkg::FIRE_MIN;
    end else if (direct_q) begin
      firing_angle <= post_ramp_reference;
    end else begin
      firing_angle <= loop_angle;
    end
  end
  property p_standstill_angle;
    @(posedge pclk) disable iff (!presetn)
    ss_engage |=> firing_angle == aclc_pkg::FIRE_MIN;
  endproperty
  a_standstill_angle: assert property (p_standstill_angle) else $error("Standstill not phased back");
  property p_direct_angle;
    @(posedge pclk) disable iff (!presetn)
    !ss_engage && direct_q |=> firing_angle == $past(post_ramp_reference);
  endproperty
  a_direct_angle: assert property (p_direct_angle) else $error("Direct firing angle wrong");
  assign fire_enable = !inhibit_q && !ss_inhibit && !trip_q;
  assign ramp_reset = inhibit_q;
  // ----------------------------------------
  // Bridge lockout
  // ----------------------------------------
  assign bridge_change_grant = bridge_change_request && !(lockout_q && partner_lockout_input);
  assign lockout_status_output = fire_enable && (current_feedback != 10'h0);
endmodule
`default_nettype wire

// ==== core/aclc_pkg.sv ====
// Package of constants and types for the armature current loop control block
package aclc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_HEAT = 8'h00;
  localparam logic [7:0] OFS_COOL = 8'h04;
  localparam logic [7:0] OFS_TUNE = 8'h08;
  localparam logic [7:0] OFS_ENDSTOP = 8'h0c;
  localparam logic [7:0] OFS_ACCUM = 8'h10;
  localparam logic [7:0] OFS_DIGAIN = 8'h14;
  localparam logic [7:0] OFS_CPGAIN = 8'h18;
  localparam logic [7:0] OFS_CIGAIN = 8'h1c;
  localparam logic [7:0] OFS_MCONST = 8'h20;
  localparam logic [7:0] OFS_RSVD = 8'h24;
  localparam logic [7:0] OFS_INHIBIT = 8'h28;
  localparam logic [7:0] OFS_SSEN = 8'h2c;
  localparam logic [7:0] OFS_SSMODE = 8'h30;
  localparam logic [7:0] OFS_DIRECT = 8'h34;
  localparam logic [7:0] OFS_LOCKOUT = 8'h38;
  localparam logic [7:0] OFS_ADAPT = 8'h3c;
  localparam logic [7:0] OFS_SQ12 = 8'h40;
  localparam logic [7:0] OFS_SER12 = 8'h44;
  localparam logic [7:0] OFS_PAR12 = 8'h48;
  localparam logic [7:0] OFS_OLTHR = 8'h4c;
  localparam logic [7:0] OFS_STATUS = 8'h50;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_HEAT = 8'h1e;
  localparam logic [7:0] RST_COOL = 8'h32;
  localparam logic [7:0] RST_GAIN = 8'h10;
  localparam logic [7:0] RST_MCONST = 8'h19;
  localparam logic RST_SSEN = 1'b1;
  localparam logic [9:0] RST_OLTHR = 10'h2bc;
  // ----------------------------------------
  // Scaling and timing
  // ----------------------------------------
  localparam logic [9:0] FULL_SCALE = 10'h3e8;
  localparam logic [10:0] ACC_MAX = 11'h7cf;
  localparam logic [9:0] FIRE_MAX = 10'h3ff;
  localparam logic [9:0] FIRE_MIN = 10'h115;
  localparam logic [9:0] STANDSTILL_SPEED = 10'h008;
  localparam int CLK_HZ = 25000000;
  localparam int READY_OPEN_MS = 50;
  localparam int READY_OPEN_CYC = CLK_HZ / 1000 * READY_OPEN_MS;
  localparam int TICK_CYC = 25000;
  localparam int SS_DELAY_TICKS = 100;
  localparam logic [10:0] ENDSTOP_NORMAL = 11'h488;
  localparam logic [10:0] ENDSTOP_REDUCED = 11'h41a;
  typedef enum logic [2:0] {
    TUNE_IDLE = 3'b001,
    TUNE_RUN = 3'b010,
    TUNE_OPEN = 3'b100
  } tune_state_type;
endpackage

// ==== verification/aclc_partner.sv ====
// Partner drive model: lockout status line and autotune completion
`timescale 1ns/1ns
`default_nettype none
module aclc_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the block
  input wire logic tune_active,
  // Bench control
  input wire logic conducting,
  // To the block
  output logic partner_lockout_input,
  output logic tune_done
);
  logic [4:0] tune_cnt_q;
  // The other drive's status output is wired straight to our input
  assign partner_lockout_input = conducting;
  // ----------------------------------------
  // Tuning run
  // ----------------------------------------
  // A slow finish, so the block must wait for the answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_cnt_q <= 5'h00;
    end else if (tune_active && tune_cnt_q != 5'h1f) begin
      tune_cnt_q <= tune_cnt_q + 5'h01;
    end else if (!tune_active) begin
      tune_cnt_q <= 5'h00;
    end
  end
  assign tune_done = tune_active && (tune_cnt_q == 5'h1f);
endmodule
`default_nettype wire

// ==== verification/aclc_top_tb.sv ====
// Self-checking testbench for the armature current loop control block
`timescale 1ns/1ns
`default_nettype none
module aclc_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen;
  logic [9:0] cur_fb = 10'h000, spd_fb = 10'h000, ref_v = 10'h000, dem = 10'h000, lerr = 10'h000;
  logic start = 1'b0, stop = 1'b0, zref = 1'b0, creset = 1'b0, b2q = 1'b0, bcreq = 1'b0, cond = 1'b0;
  logic tune_done, plock, fire_en, ramp_rst, trip, ready, tune_act, divert, grant, lstat, hgd;
  logic [9:0] fang;
  logic [10:0] endstop;
  logic [17:0] dig, cpg, cig, sdem;
  int err_count = 0, total_checks = 0, cyc = 0;
  logic [31:0] rst_tab [20] = '{32'h1e, 32'h32, 32'h0, 32'h0, 32'h0, 32'h10, 32'h10, 32'h10, 32'h19, 32'h0,
    32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2bc};
  aclc_top i_aclc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_feedback(cur_fb), .speed_feedback(spd_fb), .post_ramp_reference(ref_v), .current_demand(dem),
    .loop_error(lerr), .start_command(start), .stop_command(stop), .zero_reference(zref),
    .tune_done(tune_done), .cyclic_reset(creset), .bridge2_quadrant_enabled(b2q),
    .bridge_change_request(bcreq), .partner_lockout_input(plock), .firing_angle(fang),
    .fire_enable(fire_en), .ramp_reset(ramp_rst), .overload_trip(trip), .drive_ready(ready),
    .tune_active(tune_act), .endstop_limit(endstop), .di_gain_term(dig), .cp_gain_term(cpg),
    .ci_gain_term(cig), .scaled_demand(sdem), .high_gain_discontinuous(hgd),
    .divert_series_twelve(divert), .bridge_change_grant(grant), .lockout_status_output(lstat));
  aclc_partner i_aclc_partner (.pclk(pclk), .presetn(presetn), .tune_active(tune_act), .conducting(cond),
    .partner_lockout_input(plock), .tune_done(tune_done));
  // ----------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------
  initial begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ----------------------------------------
  // APB master
  // ----------------------------------------
  // Request held until pready is sampled high; data and error taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 20; i++) begin
      if (i != 4) begin
        apb(1'b0, 8'(i * 4), 32'h0);
        chk("reset value", rst_tab[i], rd);
      end
    end
    apb(1'b1, aclc_pkg::OFS_HEAT, 32'h14);
    apb(1'b0, aclc_pkg::OFS_HEAT, 32'h0);
    chk("heat readback", 32'h14, rd);
    apb(1'b1, 8'h54, 32'h5);
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    apb(1'b0, 8'h54, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("Test registers done");
  endtask
  task automatic t_endstop_inhibit();
    chk("endstop normal", 32'(11'h488), 32'(endstop));
    apb(1'b1, aclc_pkg::OFS_ENDSTOP, 32'h1);
    chk("endstop reduced", 32'(11'h41a), 32'(endstop));
    apb(1'b1, aclc_pkg::OFS_INHIBIT, 32'h1);
    chk("fire inhibited", 32'h0, 32'(fire_en));
    chk("ramp reset", 32'h1, 32'(ramp_rst));
    apb(1'b1, aclc_pkg::OFS_INHIBIT, 32'h0);
    chk("ramp released", 32'h0, 32'(ramp_rst));
    apb(1'b1, aclc_pkg::OFS_ADAPT, 32'h1);
    chk("single algorithm", 32'h0, 32'(hgd));
    lerr <= 10'h3ff;
    dem <= 10'h3ff;
    apb(1'b1, aclc_pkg::OFS_DIGAIN, 32'hff);
    apb(1'b1, aclc_pkg::OFS_MCONST, 32'hff);
    chk("di gain term", (1023 * 255) / 512, 32'(dig));
    chk("cp gain term", (1023 * 16) / 512, 32'(cpg));
    chk("ci gain term", (1023 * 16) / 1024, 32'(cig));
    chk("scaled demand", 1023 * 255, 32'(sdem));
    $display("Test endstop and inhibit done");
  endtask
  task automatic t_direct_standstill();
    apb(1'b1, aclc_pkg::OFS_DIRECT, 32'h1);
    spd_fb <= 10'h200;
    ref_v <= 10'h258;
    wait_cyc(8);
    chk("direct angle", 32'(10'h258), 32'(fang));
    ref_v <= 10'h3ff;
    wait_cyc(8);
    chk("full forward", 32'(10'h3ff), 32'(fang));
    apb(1'b1, aclc_pkg::OFS_SSMODE, 32'h1);
    spd_fb <= 10'h000;
    zref <= 1'b1;
    dem <= 10'h300;
    wait_cyc(20);
    chk("reference alone ignored", 32'(10'h3ff), 32'(fang));
    apb(1'b1, aclc_pkg::OFS_DIRECT, 32'h0);
    apb(1'b1, aclc_pkg::OFS_SSMODE, 32'h0);
    wait_cyc(20);
    chk("zero reference phase back", 32'(aclc_pkg::FIRE_MIN), 32'(fang));
    zref <= 1'b0;
    stop <= 1'b1;
    wait_cyc(20);
    chk("stop phase back", 32'(aclc_pkg::FIRE_MIN), 32'(fang));
    chk("not yet inhibited", 32'h1, 32'(fire_en));
    stop <= 1'b0;
    wait_cyc(2);
    chk("loop angle", 32'h300, 32'(fang));
    $display("Test direct and standstill done");
  endtask
  task automatic t_lockout_series();
    apb(1'b1, aclc_pkg::OFS_LOCKOUT, 32'h1);
    apb(1'b1, aclc_pkg::OFS_PAR12, 32'h1);
    cond <= 1'b1;
    bcreq <= 1'b1;
    wait_cyc(2);
    chk("change held", 32'h0, 32'(grant));
    cond <= 1'b0;
    wait_cyc(2);
    chk("change granted", 32'h1, 32'(grant));
    chk("status idle", 32'h0, 32'(lstat));
    bcreq <= 1'b0;
    b2q <= 1'b1;
    apb(1'b1, aclc_pkg::OFS_SQ12, 32'h1);
    creset <= 1'b1;
    wait_cyc(1);
    creset <= 1'b0;
    wait_cyc(3);
    chk("blocked divert", 32'h0, 32'(divert));
    apb(1'b0, aclc_pkg::OFS_SQ12, 32'h0);
    chk("request cleared", 32'h0, rd);
    apb(1'b1, aclc_pkg::OFS_SER12, 32'h1);
    b2q <= 1'b0;
    apb(1'b1, aclc_pkg::OFS_SQ12, 32'h1);
    wait_cyc(3);
    chk("not sampled yet", 32'h0, 32'(divert));
    creset <= 1'b1;
    wait_cyc(1);
    creset <= 1'b0;
    wait_cyc(3);
    chk("diverted", 32'h1, 32'(divert));
    $display("Test lockout and series done");
  endtask
  task automatic t_tune();
    int n;
    apb(1'b1, aclc_pkg::OFS_TUNE, 32'h1);
    start <= 1'b1;
    n = 0;
    while (tune_act !== 1'b1 && n < 20) begin
      wait_cyc(1);
      n++;
    end
    chk("tune running", 32'h1, 32'(tune_act));
    chk("ready before done", 32'h1, 32'(ready));
    wait_cyc(40);
    start <= 1'b0;
    chk("ready open", 32'h0, 32'(ready));
    wait_cyc(500);
    chk("ready still open", 32'h0, 32'(ready));
    apb(1'b0, aclc_pkg::OFS_TUNE, 32'h0);
    chk("enable kept", 32'h1, rd);
    $display("Test autotune done");
  endtask
  task automatic t_trip();
    int n;
    apb(1'b1, aclc_pkg::OFS_OLTHR, 32'd998);
    apb(1'b1, aclc_pkg::OFS_HEAT, 32'h1);
    cur_fb <= 10'h3e8;
    wait_cyc(2);
    chk("no early trip", 32'h0, 32'(trip));
    chk("status conducting", 32'h1, 32'(lstat));
    n = 0;
    while (trip !== 1'b1 && n < 30000) begin
      wait_cyc(1);
      n++;
    end
    chk("overload trip", 32'h1, 32'(trip));
    chk("trip stops firing", 32'h0, 32'(fire_en));
    apb(1'b0, aclc_pkg::OFS_ACCUM, 32'h0);
    chk("accumulator", ((1000 - 998) * 10) / 16, rd);
    $display("Test overload done");
  endtask
  initial begin
    wait_cyc(4);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_endstop_inhibit();
    t_direct_standstill();
    t_lockout_series();
    t_tune();
    t_trip();
    complete_run();
  end
endmodule
`default_nettype wire
